// *** design/cvsd_pcm_voice_converter.sv ***
/*
  Voice converter between 8 kHz PCM and a packed delta-modulated word stream, with its word FIFOs.
  Assumes bus-side logic on clk_sys drives the strobes; the converter derives the 125 us sample pace from clk_sys.
*/
// How it works
// - one PCM sample each 125 us
// - sixteen delta bits packed per word, 4 kHz
// - eight-word FIFOs for delta words both ways
// - double-buffered PCM in and out registers
// - PCM interrupt once per sample period
// - DMA request once per sample period
// - delta interrupt on in-low or out-high
// - warn at three left or three free
// - interpolate 8 kHz to 64 kHz
// - slope-adaptive delta encoder, standard voice constants
// - decode bits then decimate to 8 kHz
// - PCM format applied automatically during conversion
// - select bit, write input, read output
// - stand-alone conversion not tied to rate
// - only log to linear or back
// - mu-law linear is left-aligned 14 bits
// - A-law linear is left-aligned 13 bits
// - clock enable off stops delta conversion and sample pacing
// - format bits pick log or linear input
// - delta math on 16-bit two's complement
// - resolution shifts input right 0-3 bits
// - log input expanded to 16-bit linear
// - reuse old sample if none arrived
// - empty input FIFO yields checkerboard
// - full output FIFO drops word, sets flag
`timescale 1ns/1ns
`include "cvsd_pcm_params.svh"

////////////////////////////////////////////////////////////////////////////////
module word_fifo #(
  parameter int WIDTH = `CVSD_WORD_BITS,
  parameter int DEPTH = `CVSD_FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [AW:0]      count
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_state_type;

  fifo_state_type s_q;
  fifo_state_type s_d;
  logic           push;
  logic           pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  assign in_ready  = (s_q.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rd];
  assign count     = s_q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = bump(s_q.wr);
    end
    if (pop) begin
      s_d.rd = bump(s_q.rd);
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + (AW + 1)'(1);
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - (AW + 1)'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : word_fifo

////////////////////////////////////////////////////////////////////////////////
module cvsd_pcm_voice_converter #(
  parameter int FIFO_DEPTH = `CVSD_FIFO_DEPTH
) (
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  input  wire logic                         converter_clock_enable,
  input  wire cvsd_pcm_pkg::format_type      delta_conv_format_select,
  input  wire logic [1:0]                   resolution,
  input  wire cvsd_pcm_pkg::conv_select_type pcm_format_conv_select,
  input  wire logic                         pcm_irq_enable,
  input  wire logic                         cvsd_irq_enable,
  input  wire logic                         cvsd_err_irq_enable,
  input  wire logic                         pcm_dma_enable,
  input  wire logic [15:0]                  pcm_in_data,
  input  wire logic                         pcm_in_write,
  output logic      [15:0]                  pcm_out_data,
  input  wire logic                         pcm_out_read,
  output logic                              pcm_out_full,
  output logic                              pcm_in_empty,
  input  wire logic [15:0]                  cvsd_in_data,
  input  wire logic                         cvsd_in_valid,
  output logic                              cvsd_in_ready,
  output logic      [15:0]                  cvsd_out_data,
  output logic                              cvsd_out_valid,
  input  wire logic                         cvsd_out_ready,
  output logic      [$clog2(FIFO_DEPTH):0]  cvsd_in_count,
  output logic      [$clog2(FIFO_DEPTH):0]  cvsd_out_count,
  output logic                              cvsd_out_overflow,
  input  wire logic                         cvsd_out_overflow_clear,
  input  wire logic [7:0]                   log_pcm_input,
  input  wire logic                         log_pcm_write,
  input  wire logic [15:0]                  linear_pcm_input,
  input  wire logic                         linear_pcm_write,
  output logic      [7:0]                   log_pcm_output,
  output logic      [15:0]                  linear_pcm_output,
  output logic                              irq,
  output logic                              dma_request
);
  import cvsd_pcm_pkg::*;
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    logic [11:0] ph;
    logic [2:0]  sub;
    logic [15:0] pin_hold;
    logic        pin_new;
    logic [15:0] prev;
    logic [15:0] cur;
    logic [15:0] enc_acc;
    logic [15:0] enc_delta;
    logic [3:0]  enc_hist;
    logic [15:0] enc_word;
    logic [3:0]  enc_cnt;
    logic [15:0] dec_acc;
    logic [15:0] dec_delta;
    logic [3:0]  dec_hist;
    logic [15:0] dec_word;
    logic [3:0]  dec_cnt;
    logic [18:0] dec_sum;
    logic [15:0] pcm_out;
    logic        pout_full;
    logic        overflow;
    logic [7:0]  log_out;
    logic [15:0] lin_out;
    logic        irq;
    logic        dma;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic            push_valid;
  logic            push_ready;
  logic [15:0]     push_word;
  logic            pop_ready;
  logic            pop_valid;
  logic [15:0]     pop_word;
  logic [CW-1:0]   in_cnt;
  logic [CW-1:0]   out_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // companding: mu-law works on 14 left-aligned bits, A-law on 13
  function automatic logic [3:0] top_bit(input logic [13:0] v);
    top_bit = 4'h0;
    for (int i = 0; i < 14; i++) begin
      if (v[i]) top_bit = 4'(i);
    end
  endfunction : top_bit

  function automatic logic [15:0] mu_expand(input logic [7:0] code);
    logic [7:0]  u;
    logic [15:0] mag;
    u = ~code;
    mag = ((16'({u[3:0], 3'h0}) + 16'h0084) << u[6:4]) - 16'h0084;
    mu_expand = u[7] ? 16'(-mag) : mag;
  endfunction : mu_expand

  function automatic logic [7:0] mu_compress(input logic [15:0] x);
    logic [13:0] v;
    logic [13:0] mag;
    logic [2:0]  e;
    v = x[15:2];
    mag = v[13] ? 14'(-v) : v;
    if (mag > `CVSD_MU_CLIP) mag = `CVSD_MU_CLIP;
    mag = mag + `CVSD_MU_BIAS;
    e = 3'(top_bit(mag) - 4'h5);
    mu_compress = ~{v[13], e, 4'(mag >> (4'(e) + 4'h1))};
  endfunction : mu_compress

  function automatic logic [15:0] a_expand(input logic [7:0] code);
    logic [7:0]  a;
    logic [15:0] mag;
    a = code ^ 8'h55;
    if (a[6:4] == 3'h0) mag = 16'({a[3:0], 1'h1});
    else mag = (16'({a[3:0], 1'h1}) + 16'h0020) << (a[6:4] - 3'h1);
    a_expand = a[7] ? 16'(mag << 3) : 16'(-(mag << 3));
  endfunction : a_expand

  function automatic logic [7:0] a_compress(input logic [15:0] x);
    logic [12:0] v;
    logic [12:0] mag;
    logic [2:0]  e;
    v = x[15:3];
    mag = v[12] ? ~v : v;
    if (mag > `CVSD_A_CLIP) mag = `CVSD_A_CLIP;
    e = (mag < 13'h0020) ? 3'h0 : 3'(top_bit({1'h0, mag}) - 4'h4);
    a_compress = {~v[12], e, (e == 3'h0) ? 4'(mag >> 1) : 4'(mag >> e)} ^ 8'h55;
  endfunction : a_compress

  // slope-adaptive step; returns {new accumulator, new step}
  function automatic logic [31:0] delta_step(input logic [15:0] acc, input logic [15:0] dlt,
                                             input logic [3:0] hist, input logic bit_in);
    logic [15:0] nd;
    logic [17:0] y;
    logic [15:0] ys;
    if (hist == 4'hF || hist == 4'h0) begin
      nd = (dlt + `CVSD_DELTA_MIN > `CVSD_DELTA_MAX) ? `CVSD_DELTA_MAX : dlt + `CVSD_DELTA_MIN;
    end else begin
      nd = dlt - (dlt >> `CVSD_STEP_DECAY_SHIFT);
      if (nd < `CVSD_DELTA_MIN) nd = `CVSD_DELTA_MIN;
    end
    y = bit_in ? 18'($signed(acc)) + 18'(nd) : 18'($signed(acc)) - 18'(nd);
    if ($signed(y) > $signed(18'h07FFF)) ys = 16'h7FFF;
    else if ($signed(y) < $signed(18'h38000)) ys = 16'h8000;
    else ys = y[15:0];
    delta_step = {16'($signed(ys) - ($signed(ys) >>> `CVSD_ACC_DECAY_SHIFT)), nd};
  endfunction : delta_step

  //////////////////////////////////////////////////////////////////////////////
  word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) in_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_data   (cvsd_in_data),
    .in_valid  (cvsd_in_valid),
    .in_ready  (cvsd_in_ready),
    .out_data  (pop_word),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .count     (in_cnt)
  );

  word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) out_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_data   (push_word),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (cvsd_out_data),
    .out_valid (cvsd_out_valid),
    .out_ready (cvsd_out_ready),
    .count     (out_cnt)
  );

  //////////////////////////////////////////////////////////////////////////////
  logic [12:0] ph_sum;
  logic        sub_tick;
  logic        sample_tick;
  logic [15:0] expanded;
  logic [15:0] scaled;
  logic [16:0] diff;
  logic [19:0] ramp;
  logic [15:0] interp;
  logic        enc_bit;
  logic [31:0] enc_next;
  logic [15:0] dec_src;
  logic        dec_bit;
  logic [31:0] dec_next;
  logic [15:0] decim;

  always_comb begin
    s_d = s_q;
    ph_sum = 13'(s_q.ph) + 13'(`CVSD_SUBSTEPS);
    sub_tick = converter_clock_enable && (ph_sum >= 13'(`CVSD_SAMPLE_CYCLES));
    sample_tick = sub_tick && (s_q.sub == 3'(`CVSD_SUBSTEPS - 1));
    // input selection and scaling
    unique case (delta_conv_format_select)
      fmt_mu_law: expanded = mu_expand(s_q.pin_hold[7:0]);
      fmt_a_law:  expanded = a_expand(s_q.pin_hold[7:0]);
      default:    expanded = s_q.pin_hold;
    endcase
    scaled = 16'($signed(expanded) >>> resolution);
    // linear ramp from prev toward cur across the eight substeps
    diff = 17'($signed(s_q.cur)) - 17'($signed(s_q.prev));
    ramp = 20'($signed(diff) * $signed({1'h0, s_q.sub}));
    interp = 16'($signed(s_q.prev) + 16'($signed(ramp) >>> 3));
    enc_bit = ($signed(interp) >= $signed(s_q.enc_acc));
    enc_next = delta_step(s_q.enc_acc, s_q.enc_delta, {s_q.enc_hist[2:0], enc_bit}, enc_bit);
    // a fresh word is fetched only when the previous one is spent
    dec_src = (s_q.dec_cnt != 4'h0) ? s_q.dec_word : (pop_valid ? pop_word : `CVSD_CHECKERBOARD);
    dec_bit = dec_src[0];
    dec_next = delta_step(s_q.dec_acc, s_q.dec_delta, {s_q.dec_hist[2:0], dec_bit}, dec_bit);
    decim = 16'($signed(19'(s_q.dec_sum) + 19'($signed(dec_next[31:16]))) >>> 3);
    push_word = {enc_bit, s_q.enc_word[15:1]};
    push_valid = sub_tick && (s_q.enc_cnt == 4'hF);
    pop_ready = sub_tick && (s_q.dec_cnt == 4'h0);

    if (pcm_in_write) begin
      s_d.pin_hold = pcm_in_data;
      s_d.pin_new = 1'h1;
    end
    if (pcm_out_read) begin
      s_d.pout_full = 1'h0;
    end
    if (cvsd_out_overflow_clear) begin
      s_d.overflow = 1'h0;
    end

    if (converter_clock_enable) begin
      s_d.ph = sub_tick ? 12'(ph_sum - 13'(`CVSD_SAMPLE_CYCLES)) : ph_sum[11:0];
    end
    if (sub_tick) begin
      s_d.sub = s_q.sub + 3'h1;
      s_d.enc_acc = enc_next[31:16];
      s_d.enc_delta = enc_next[15:0];
      s_d.enc_hist = {s_q.enc_hist[2:0], enc_bit};
      s_d.enc_word = push_word; // oldest bit lands in bit 0
      s_d.enc_cnt = s_q.enc_cnt + 4'h1;
      if (push_valid && !push_ready) begin
        s_d.overflow = 1'h1;
      end
      s_d.dec_acc = dec_next[31:16];
      s_d.dec_delta = dec_next[15:0];
      s_d.dec_hist = {s_q.dec_hist[2:0], dec_bit};
      s_d.dec_word = {1'h0, dec_src[15:1]};
      s_d.dec_cnt = s_q.dec_cnt + 4'h1;
      s_d.dec_sum = 19'(s_q.dec_sum) + 19'($signed(dec_next[31:16]));
    end
    if (sample_tick) begin
      // an absent sample repeats, keeping the rate fixed
      s_d.prev = s_q.cur;
      s_d.cur = scaled;
      s_d.pin_new = pcm_in_write;
      s_d.dec_sum = '0;
      unique case (delta_conv_format_select)
        fmt_mu_law: s_d.pcm_out = {8'h00, mu_compress(decim)};
        fmt_a_law:  s_d.pcm_out = {8'h00, a_compress(decim)};
        default:    s_d.pcm_out = decim;
      endcase
      s_d.pout_full = 1'h1;
    end

    // stand-alone path: result one edge after the write, at any time
    if (log_pcm_write) begin
      s_d.lin_out = (pcm_format_conv_select == conv_a_law) ? a_expand(log_pcm_input) : mu_expand(log_pcm_input);
    end
    if (linear_pcm_write) begin
      s_d.log_out = (pcm_format_conv_select == conv_a_law) ? a_compress(linear_pcm_input)
                                                             : mu_compress(linear_pcm_input);
    end

    s_d.irq = (pcm_irq_enable && sample_tick)
           || (cvsd_irq_enable && (in_cnt == CW'(`CVSD_IN_WARN_COUNT)
                                   || out_cnt >= CW'(`CVSD_OUT_WARN_COUNT)))
           || (cvsd_err_irq_enable && (s_q.overflow || (in_cnt == '0 && converter_clock_enable)));
    s_d.dma = pcm_dma_enable && sample_tick;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
      s_q.enc_delta <= `CVSD_DELTA_MIN;
      s_q.dec_delta <= `CVSD_DELTA_MIN;
    end else begin
      s_q <= s_d;
    end
  end

  assign pcm_out_data      = s_q.pcm_out;
  assign pcm_out_full      = s_q.pout_full;
  assign pcm_in_empty      = !s_q.pin_new;
  assign cvsd_in_count     = in_cnt;
  assign cvsd_out_count    = out_cnt;
  assign cvsd_out_overflow = s_q.overflow;
  assign log_pcm_output    = s_q.log_out;
  assign linear_pcm_output = s_q.lin_out;
  assign irq               = s_q.irq;
  assign dma_request       = s_q.dma;
endmodule : cvsd_pcm_voice_converter

// *** shared/cvsd_pcm_params.svh ***
/*
  Timing counts, FIFO limits, reset values and delta-modulation constants for the voice converter.
  Assumes a 25 MHz system clock; included by its bare name.
*/
`ifndef CVSD_PCM_PARAMS_SVH
`define CVSD_PCM_PARAMS_SVH
`define CVSD_SAMPLE_PERIOD_NS 125000
`define CVSD_CLK_PERIOD_NS    40
`define CVSD_SAMPLE_CYCLES    (`CVSD_SAMPLE_PERIOD_NS / `CVSD_CLK_PERIOD_NS)
`define CVSD_SUBSTEPS         8
`define CVSD_WORD_BITS        16
`define CVSD_FIFO_DEPTH       8
`define CVSD_IN_WARN_COUNT    3
`define CVSD_OUT_WARN_COUNT   5
`define CVSD_CHECKERBOARD     16'hAAAA
`define CVSD_DELTA_MIN        16'h000A
`define CVSD_DELTA_MAX        16'h0500
`define CVSD_ACC_DECAY_SHIFT  5
`define CVSD_STEP_DECAY_SHIFT 10
`define CVSD_RESET_WORD       16'h0000
`define CVSD_MU_BIAS          14'h0021
`define CVSD_MU_CLIP          14'h1FDE
`define CVSD_A_CLIP           13'h0FFF
`endif

// *** shared/cvsd_pcm_pkg.sv ***
/*
  Types shared by the voice converter: PCM format selections.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cvsd_pcm_pkg;
  typedef enum logic [1:0] {
    fmt_linear = 2'h0,
    fmt_mu_law = 2'h1,
    fmt_a_law  = 2'h2
  } format_type;
  typedef enum logic {
    conv_mu_law = 1'h0,
    conv_a_law  = 1'h1
  } conv_select_type;
endpackage : cvsd_pcm_pkg

// *** dv/cvsd_pcm_voice_converter_asserts.sv ***
/*
  Port-level timing checks for the voice converter.
  Assumes binding into each converter instance; one clock, synchronous reset.
*/
`timescale 1ns/1ns
`include "cvsd_pcm_params.svh"
module cvsd_pcm_voice_converter_asserts #(
  parameter int FIFO_DEPTH = `CVSD_FIFO_DEPTH
) (
  input wire logic                        clk_sys,
  input wire logic                        srst,
  input wire logic                        converter_clock_enable,
  input wire logic                        pcm_irq_enable,
  input wire logic                        cvsd_irq_enable,
  input wire logic                        cvsd_err_irq_enable,
  input wire logic                        pcm_out_full,
  input wire logic                        cvsd_in_ready,
  input wire logic [$clog2(FIFO_DEPTH):0] cvsd_in_count,
  input wire logic                        cvsd_out_valid,
  input wire logic [$clog2(FIFO_DEPTH):0] cvsd_out_count,
  input wire logic                        cvsd_out_overflow,
  input wire logic                        cvsd_out_overflow_clear,
  input wire logic                        irq,
  input wire logic                        dma_request
);
  localparam int GAP = `CVSD_SAMPLE_CYCLES - 1;
  logic [11:0] gap_q;
  logic        armed_q;
  // the gap is only meaningful while the converter clock ran the whole period
  always_ff @(posedge clk_sys) begin
    if (srst || !converter_clock_enable) begin
      armed_q <= 1'b0;
      gap_q   <= 12'h000;
    end else if (dma_request) begin
      armed_q <= 1'b1;
      gap_q   <= 12'h000;
    end else begin
      gap_q <= gap_q + 12'h001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_dma_gap; dma_request && armed_q |-> gap_q == GAP; endproperty
  a_dma_gap: assert property (p_dma_gap) else $error("sample request spacing wrong");
  property p_dma_pulse; dma_request |=> !dma_request; endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("sample request longer than one cycle");
  property p_dma_full; dma_request |-> pcm_out_full; endproperty
  a_dma_full: assert property (p_dma_full) else $error("request without fresh output sample");
  property p_in_ready; cvsd_in_ready == (cvsd_in_count < FIFO_DEPTH); endproperty
  a_in_ready: assert property (p_in_ready) else $error("input ready disagrees with count");
  property p_out_valid; cvsd_out_valid == (cvsd_out_count != 0) && cvsd_out_count <= FIFO_DEPTH; endproperty
  a_out_valid: assert property (p_out_valid) else $error("output valid disagrees with count");
  property p_warn; cvsd_irq_enable && (cvsd_in_count == 4'h3 || cvsd_out_count >= 4'h5) |=> irq; endproperty
  a_warn: assert property (p_warn) else $error("fifo warning did not interrupt");
  property p_ovf_cause; $rose(cvsd_out_overflow) |-> $past(cvsd_out_count) == FIFO_DEPTH; endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without full fifo");
  property p_ovf_sticky; cvsd_out_overflow && !cvsd_out_overflow_clear |=> cvsd_out_overflow; endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
  property p_quiet; !pcm_irq_enable && !cvsd_irq_enable && !cvsd_err_irq_enable |=> !irq; endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt with all causes off");
  property p_err; cvsd_err_irq_enable && cvsd_out_overflow |=> irq; endproperty
  a_err: assert property (p_err) else $error("overflow did not interrupt");
endmodule : cvsd_pcm_voice_converter_asserts

bind cvsd_pcm_voice_converter cvsd_pcm_voice_converter_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .clk_sys, .srst, .converter_clock_enable, .pcm_irq_enable, .cvsd_irq_enable, .cvsd_err_irq_enable,
  .pcm_out_full, .cvsd_in_ready, .cvsd_in_count, .cvsd_out_valid, .cvsd_out_count, .cvsd_out_overflow,
  .cvsd_out_overflow_clear, .irq, .dma_request
);

// *** dv/pcm_bus_model.sv ***
/*
  Stand-in for the processor and DMA side: answers each sample request, drains on demand.
  Assumes strobes are sampled on the rising clk_sys edge.
*/
`timescale 1ns/1ns
module pcm_bus_model (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        dma_request,
  input  wire logic        cvsd_out_valid,
  input  wire logic        drain,
  output logic      [15:0] pcm_in_data,
  output logic             pcm_in_write,
  output logic             pcm_out_read,
  output logic             cvsd_out_ready,
  output int               pops
);
  initial begin
    pcm_in_data    = 16'h0001;
    pcm_in_write   = 1'b0;
    pcm_out_read   = 1'b0;
    cvsd_out_ready = 1'b0;
    pops           = 0;
  end
  // data wanders every cycle so a stale value is never mistaken for a sample
  always @(negedge clk_sys) begin
    pcm_in_data    <= {pcm_in_data[14:0], ~pcm_in_data[15]};
    pcm_in_write   <= dma_request && !srst;
    pcm_out_read   <= dma_request && !srst;
    cvsd_out_ready <= drain;
  end
  always @(posedge clk_sys) begin
    pops <= srst ? 0 : pops + (cvsd_out_valid && cvsd_out_ready);
  end
endmodule : pcm_bus_model

// *** dv/cvsd_pcm_voice_converter_tb.sv ***
/*
  Bench for the voice converter: stand-alone conversion, sample pacing, word FIFOs.
  Assumes pcm_bus_model answers requests; inputs change at the falling edge.
*/
`timescale 1ns/1ns
`include "cvsd_pcm_params.svh"
module cvsd_pcm_voice_converter_tb;
  import cvsd_pcm_pkg::*;
  logic clk_sys = 1'b0;
  logic srst, converter_clock_enable, pcm_irq_enable, cvsd_irq_enable, cvsd_err_irq_enable, pcm_dma_enable;
  logic pcm_in_write, pcm_out_read, pcm_out_full, pcm_in_empty, cvsd_in_valid, cvsd_in_ready, drain;
  logic cvsd_out_valid, cvsd_out_ready, cvsd_out_overflow, cvsd_out_overflow_clear, irq, dma_request;
  logic log_pcm_write, linear_pcm_write;
  logic [15:0] pcm_in_data, pcm_out_data, cvsd_in_data, cvsd_out_data, linear_pcm_input, linear_pcm_output;
  logic [7:0]  log_pcm_input, log_pcm_output;
  logic [1:0]  resolution;
  logic [15:0] head;
  logic [3:0]  cvsd_in_count, cvsd_out_count;
  int          pops, n, bad_count, cmp_count;
  format_type      delta_conv_format_select;
  conv_select_type pcm_format_conv_select;
  always #(`CVSD_CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  cvsd_pcm_voice_converter uut (
    .clk_sys, .srst, .converter_clock_enable, .delta_conv_format_select, .resolution,
    .pcm_format_conv_select, .pcm_irq_enable, .cvsd_irq_enable, .cvsd_err_irq_enable, .pcm_dma_enable,
    .pcm_in_data, .pcm_in_write, .pcm_out_data, .pcm_out_read, .pcm_out_full, .pcm_in_empty,
    .cvsd_in_data, .cvsd_in_valid, .cvsd_in_ready, .cvsd_out_data, .cvsd_out_valid, .cvsd_out_ready,
    .cvsd_in_count, .cvsd_out_count, .cvsd_out_overflow, .cvsd_out_overflow_clear, .log_pcm_input,
    .log_pcm_write, .linear_pcm_input, .linear_pcm_write, .log_pcm_output, .linear_pcm_output, .irq, .dma_request
  );
  pcm_bus_model host (
    .clk_sys, .srst, .dma_request, .cvsd_out_valid, .drain, .pcm_in_data, .pcm_in_write, .pcm_out_read,
    .cvsd_out_ready, .pops
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t word %h, expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t flag %b, expected %b", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : cyc
  function automatic logic hit(input int w);
    case (w)
      0: return dma_request === 1'b1;
      1: return cvsd_in_count === 4'h3;
      2: return cvsd_out_overflow === 1'b1;
      default: return cvsd_out_count === 4'h0;
    endcase
  endfunction : hit
  task automatic wait_for(input int w, output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (!hit(w) && k < 70000);
  endtask : wait_for
  // result is looked at one edge after the write, the registered answer time
  task automatic conv(input logic to_lin, input conv_select_type sel, input logic [15:0] din, input logic [15:0] exp);
    cyc(1);
    pcm_format_conv_select = sel;
    log_pcm_input = din[7:0];
    linear_pcm_input = din;
    log_pcm_write = to_lin;
    linear_pcm_write = !to_lin;
    cyc(1);
    log_pcm_write = 1'b0;
    linear_pcm_write = 1'b0;
    cmp_word(to_lin ? linear_pcm_output : {8'h00, log_pcm_output}, exp);
  endtask : conv
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(`CVSD_CLK_PERIOD_NS * 90000);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
  initial begin
    {srst, converter_clock_enable, pcm_irq_enable, cvsd_irq_enable, cvsd_err_irq_enable} = 5'h10;
    {pcm_dma_enable, cvsd_in_valid, drain, cvsd_out_overflow_clear, log_pcm_write, linear_pcm_write} = 6'h00;
    {cvsd_in_data, linear_pcm_input, log_pcm_input} = 40'h00_0000_0000;
    delta_conv_format_select = fmt_linear;
    resolution = 2'h0;
    pcm_format_conv_select = conv_mu_law;
    bad_count = 0;
    cmp_count = 0;
    cyc(4);
    srst = 1'b0;
    cmp_bit(pcm_in_empty, 1'b1);
    cmp_bit(cvsd_in_ready, 1'b1);
    cmp_bit(cvsd_out_valid, 1'b0);
    cmp_word(pcm_out_data, 16'h0000);
    $display("test reset done");
    pcm_dma_enable = 1'b1;
    conv(1'b1, conv_mu_law, 16'h00FF, 16'h0000);
    conv(1'b1, conv_mu_law, 16'h0080, 16'h7D7C);
    conv(1'b1, conv_a_law, 16'h00D5, 16'h0008);
    conv(1'b1, conv_a_law, 16'h00AA, 16'h7E00);
    conv(1'b0, conv_mu_law, 16'h0003, 16'h00FF);
    conv(1'b0, conv_mu_law, 16'h7FFC, 16'h0080);
    conv(1'b0, conv_a_law, 16'h0007, 16'h00D5);
    conv(1'b0, conv_a_law, 16'h7FF8, 16'h00AA);
    n = 0;
    repeat (3200) begin
      cyc(1);
      n += (dma_request === 1'b1);
    end
    cmp_word(16'(n), 16'h0000);
    $display("test stand-alone conversion done");
    converter_clock_enable = 1'b1;
    pcm_irq_enable = 1'b1;
    wait_for(0, n);
    cmp_bit(irq, 1'b1);
    cmp_bit(pcm_out_full, 1'b1);
    cyc(2);
    cmp_bit(pcm_in_empty, 1'b0);
    cmp_bit(pcm_out_full, 1'b0);
    wait_for(0, n);
    cmp_word(16'(n + 2), 16'(`CVSD_SAMPLE_CYCLES));
    cmp_bit(pcm_in_empty, 1'b1);
    $display("test sample pacing done");
    pcm_irq_enable = 1'b0;
    cvsd_irq_enable = 1'b1;
    cvsd_in_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      cvsd_in_data = 16'hA5C3 ^ 16'(i);
      n = 0;
      while (cvsd_in_ready !== 1'b1 && n < 100) begin
        cyc(1);
        n++;
      end
      cyc(1);
    end
    cyc(3);
    cmp_bit(cvsd_in_ready, 1'b0);
    cmp_word(16'(cvsd_in_count), 16'h0008);
    cvsd_in_valid = 1'b0;
    wait_for(1, n);
    // oldest output word; a dropped push must not overwrite it
    head = cvsd_out_data;
    cyc(1);
    cmp_bit(irq, 1'b1);
    cvsd_err_irq_enable = 1'b1;
    wait_for(2, n);
    cmp_word(16'(cvsd_out_count), 16'h0008);
    cmp_word(cvsd_out_data, head);
    cyc(1);
    cmp_bit(irq, 1'b1);
    drain = 1'b1;
    wait_for(3, n);
    drain = 1'b0;
    cyc(2);
    cmp_bit(cvsd_out_valid, 1'b0);
    cmp_word(16'(pops), 16'h0008);
    cvsd_out_overflow_clear = 1'b1;
    cyc(1);
    cvsd_out_overflow_clear = 1'b0;
    cyc(1);
    cmp_bit(cvsd_out_overflow, 1'b0);
    $display("test word fifos done");
    close_out();
  end
endmodule : cvsd_pcm_voice_converter_tb
